//--- dmw_command_decoder.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
module dmw_command_decoder (
   // Clock and reset.
   input  wire  logic                   mclk,
   input  wire  logic                   rst_n,
   // Host command bus.
   input  wire  logic                   hostWrite,
   input  wire  logic                   cmdDataSelect,
   input  wire  logic [23:0]            hostData,
   // Panel timing.
   input  wire  logic                   frameStart,
   // APB slave.
   input  wire  logic                   psel,
   input  wire  logic                   penable,
   input  wire  logic                   pwrite,
   input  wire  logic [11:0]            paddr,
   input  wire  logic [31:0]            pwdata,
   output       logic                   pready,
   output       logic [31:0]            prdata,
   output       logic                   pslverr,
   // Frame memory write port and panel state.
   output       dmw_pkg::dmw_memwr_type memWrite,
   output       dmw_pkg::dmw_panel_type panelState
);

   // ************************************************************
   // Declarations.
   // ************************************************************
   dmw_pkg::dmw_state_type state;
   logic [dmw_pkg::CTRL_WIDTH-1:0] ctrl;
   logic [1:0]  parIndex;
   logic [9:0]  parFirst;
   logic [1:0]  parHigh;
   logic [9:0]  firstColumn;
   logic [9:0]  lastColumn;
   logic [9:0]  firstRowPage;
   logic [9:0]  lastRowPage;
   logic [9:0]  colCnt;
   logic [9:0]  pageCnt;
   logic        winDone;
   logic [1:0]  wordCnt;
   logic [23:0] pixAcc;
   logic        partialPending;
   logic        partialTarget;
   logic        blcClear;
   logic        isCmd;
   logic        isData;
   logic [9:0]  colLimit;
   logic [9:0]  pageLimit;
   logic [9:0]  parLast;
   logic        pixelDone;
   logic [23:0] pixelValue;
   logic [9:0]  curCol;
   logic [9:0]  curPage;
   logic        storeNow;
   logic [9:0]  next_colCnt;
   logic [9:0]  next_pageCnt;
   logic        next_winDone;
   logic [10:0] colSum;
   logic [10:0] pageSum;
   logic        apbAccess;
   logic        apbHit;
   logic        partialMode;
   logic        invertOn;
   logic        displayOn;
   logic        backlightOn;

   assign isCmd     = hostWrite & ~cmdDataSelect;
   assign isData    = hostWrite & cmdDataSelect;
   assign colLimit  = ctrl[dmw_pkg::CTRL_SWAP_BIT] ? dmw_pkg::COL_LIMIT_WIDE
                                                   : dmw_pkg::COL_LIMIT_NARROW;
   assign pageLimit = ctrl[dmw_pkg::CTRL_SWAP_BIT] ? dmw_pkg::PAGE_LIMIT_WIDE
                                                   : dmw_pkg::PAGE_LIMIT_NARROW;
   assign parLast   = {parHigh, hostData[7:0]};
   assign blcClear  = isCmd & (hostData[7:0] == dmw_pkg::CMD_INVERT_ON) & ~panelState.invertOn;

   // ************************************************************
   // Panel state outputs.
   // ************************************************************
   assign panelState = {partialMode,
                        invertOn,
                        displayOn,
                        backlightOn};

   // ************************************************************
   // Command sequencing.
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state    <= dmw_pkg::ST_IDLE;
         parIndex <= 2'h0;
      end else if (isCmd) begin
         parIndex <= 2'h0;
         case (hostData[7:0])
            dmw_pkg::CMD_COLUMN_SET: state <= dmw_pkg::ST_COLPAR;
            dmw_pkg::CMD_PAGE_SET:   state <= dmw_pkg::ST_PAGEPAR;
            dmw_pkg::CMD_MEM_WRITE:  state <= dmw_pkg::ST_MEMWR;
            default:                 state <= dmw_pkg::ST_IDLE;
         endcase
      end else if (isData) begin
         case (state)
            dmw_pkg::ST_COLPAR, dmw_pkg::ST_PAGEPAR: begin
               parIndex <= parIndex + 2'h1;
               if (parIndex == 2'h3) begin
                  state <= dmw_pkg::ST_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // Range parameters.
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         parHigh      <= 2'h0;
         parFirst     <= dmw_pkg::FIRST_RESET;
         firstColumn  <= dmw_pkg::FIRST_RESET;
         lastColumn   <= dmw_pkg::LAST_COL_RESET;
         firstRowPage <= dmw_pkg::FIRST_RESET;
         lastRowPage  <= dmw_pkg::LAST_PAGE_RESET;
      end else if (isData && (state == dmw_pkg::ST_COLPAR || state == dmw_pkg::ST_PAGEPAR)) begin
         case (parIndex)
            2'h0: parHigh <= hostData[1:0];
            2'h1: parFirst <= {parHigh, hostData[7:0]};
            2'h2: parHigh <= hostData[1:0];
            default: begin
               if (state == dmw_pkg::ST_COLPAR) begin
                  if (parFirst <= colLimit && parLast <= colLimit) begin
                     firstColumn <= parFirst;
                     lastColumn  <= parLast;
                  end
               end else begin
                  if (parFirst <= pageLimit && parLast <= pageLimit) begin
                     firstRowPage <= parFirst;
                     lastRowPage  <= parLast;
                  end
               end
            end
         endcase
      end
   end

   // ************************************************************
   // Pixel assembly.
   // ************************************************************
   always_comb begin
      pixelDone  = isData && (state == dmw_pkg::ST_MEMWR)
                   && (wordCnt == ctrl[dmw_pkg::CTRL_WPP_LSB +: 2]);
      pixelValue = 24'h00_0000;
      case (ctrl[dmw_pkg::CTRL_WPP_LSB +: 2])
         2'h1:    pixelValue = {8'h00, pixAcc[7:0], hostData[7:0]};
         2'h2:    pixelValue = {pixAcc[15:0], hostData[7:0]};
         default: pixelValue = hostData;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wordCnt <= 2'h0;
         pixAcc  <= 24'h00_0000;
      end else if (isCmd || pixelDone) begin
         wordCnt <= 2'h0;
      end else if (isData && state == dmw_pkg::ST_MEMWR) begin
         wordCnt <= wordCnt + 2'h1;
         pixAcc  <= {pixAcc[15:0], hostData[7:0]};
      end
   end

   // ************************************************************
   // Address counter stepping.
   // ************************************************************
   always_comb begin
      curCol       = winDone ? firstColumn : colCnt;
      curPage      = winDone ? firstRowPage : pageCnt;
      storeNow     = pixelDone & (~winDone | ctrl[dmw_pkg::CTRL_WRAP_BIT]);
      next_colCnt  = curCol;
      next_pageCnt = curPage;
      next_winDone = (curCol == lastColumn) && (curPage == lastRowPage);
      if (!ctrl[dmw_pkg::CTRL_SWAP_BIT]) begin
         if (curCol == lastColumn) begin
            next_colCnt  = firstColumn;
            next_pageCnt = next_winDone ? firstRowPage : curPage + 10'h001;
         end else begin
            next_colCnt = curCol + 10'h001;
         end
      end else begin
         if (curPage == lastRowPage) begin
            next_pageCnt = firstRowPage;
            next_colCnt  = next_winDone ? firstColumn : curCol + 10'h001;
         end else begin
            next_pageCnt = curPage + 10'h001;
         end
      end
      colSum  = {1'b0, firstColumn} + {1'b0, lastColumn} - {1'b0, curCol};
      pageSum = {1'b0, firstRowPage} + {1'b0, lastRowPage} - {1'b0, curPage};
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         colCnt  <= dmw_pkg::FIRST_RESET;
         pageCnt <= dmw_pkg::FIRST_RESET;
         winDone <= 1'b0;
      end else if (isCmd && hostData[7:0] == dmw_pkg::CMD_MEM_WRITE) begin
         colCnt  <= firstColumn;
         pageCnt <= firstRowPage;
         winDone <= 1'b0;
      end else if (storeNow) begin
         colCnt  <= next_colCnt;
         pageCnt <= next_pageCnt;
         winDone <= next_winDone;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         memWrite <= '0;
      end else begin
         memWrite.enable <= storeNow;
         memWrite.pixel  <= pixelValue;
         memWrite.column <= ctrl[dmw_pkg::CTRL_CMIR_BIT] ? colSum[9:0] : curCol;
         memWrite.page   <= ctrl[dmw_pkg::CTRL_PMIR_BIT] ? pageSum[9:0] : curPage;
      end
   end

   // ************************************************************
   // Display modes.
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         partialPending <= 1'b0;
         partialTarget  <= 1'b0;
         partialMode    <= 1'b0;
      end else begin
         if (frameStart && partialPending) begin
            partialMode <= partialTarget;
         end
         if (isCmd && (hostData[7:0] == dmw_pkg::CMD_PARTIAL_ON
                       || hostData[7:0] == dmw_pkg::CMD_NORMAL_ON)) begin
            partialTarget  <= (hostData[7:0] == dmw_pkg::CMD_PARTIAL_ON);
            partialPending <= (hostData[7:0] == dmw_pkg::CMD_PARTIAL_ON)
                              != panelState.partialMode;
         end else if (frameStart) begin
            partialPending <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         invertOn  <= 1'b0;
         displayOn <= 1'b0;
      end else if (isCmd) begin
         case (hostData[7:0])
            dmw_pkg::CMD_INVERT_OFF:  invertOn  <= 1'b0;
            dmw_pkg::CMD_INVERT_ON:   invertOn  <= 1'b1;
            dmw_pkg::CMD_DISPLAY_OFF: displayOn <= 1'b0;
            dmw_pkg::CMD_DISPLAY_ON:  displayOn <= 1'b1;
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // APB register file.
   // ************************************************************
   assign apbAccess = psel & penable & pready;
   assign apbHit    = (paddr == dmw_pkg::ADDR_CTRL) || (paddr == dmw_pkg::ADDR_STATUS)
                      || (paddr == dmw_pkg::ADDR_COLWIN) || (paddr == dmw_pkg::ADDR_PAGEWIN)
                      || (paddr == dmw_pkg::ADDR_CURSOR);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl <= dmw_pkg::CTRL_RESET;
      end else begin
         if (apbAccess && pwrite && paddr == dmw_pkg::ADDR_CTRL) begin
            ctrl <= pwdata[dmw_pkg::CTRL_WIDTH-1:0];
         end
         if (blcClear) begin
            ctrl[dmw_pkg::CTRL_BLC_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         backlightOn <= 1'b0;
      end else begin
         backlightOn <= ctrl[dmw_pkg::CTRL_BLC_BIT] & ~blcClear;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~apbHit;
         prdata  <= 32'h0000_0000;
         if (psel && penable && !pready && !pwrite) begin
            case (paddr)
               dmw_pkg::ADDR_CTRL:    prdata <= {25'h000_0000, ctrl};
               dmw_pkg::ADDR_STATUS:  prdata <= {25'h000_0000, state == dmw_pkg::ST_MEMWR,
                                                 winDone, partialPending, panelState};
               dmw_pkg::ADDR_COLWIN:  prdata <= {6'h00, lastColumn, 6'h00, firstColumn};
               dmw_pkg::ADDR_PAGEWIN: prdata <= {6'h00, lastRowPage, 6'h00, firstRowPage};
               dmw_pkg::ADDR_CURSOR:  prdata <= {6'h00, pageCnt, 6'h00, colCnt};
               default:               prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : dmw_command_decoder

//--- dmw_command_decoder_chk.sv
`timescale 1ns/100ps
module dmw_command_decoder_chk (
   // Clock and reset.
   input  wire  logic                   mclk,
   input  wire  logic                   rst_n,
   // Host bus and timing.
   input  wire  logic                   hostWrite,
   input  wire  logic                   cmdDataSelect,
   input  wire  logic [23:0]            hostData,
   input  wire  logic                   frameStart,
   // APB.
   input  wire  logic                   psel,
   input  wire  logic                   penable,
   input  wire  logic                   pwrite,
   input  wire  logic [11:0]            paddr,
   input  wire  logic [31:0]            pwdata,
   input  wire  logic                   pready,
   input  wire  logic [31:0]            prdata,
   input  wire  logic                   pslverr,
   // Outputs.
   input  wire  dmw_pkg::dmw_memwr_type memWrite,
   input  wire  dmw_pkg::dmw_panel_type panelState
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic cmdW;
   assign cmdW = hostWrite && !cmdDataSelect;
   sequence cmdIs(c);
      cmdW && hostData[7:0] == c;
   endsequence
   logic modeWanted;
   logic modeWantPartial;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         modeWanted      <= 1'b0;
         modeWantPartial <= 1'b0;
      end else if (cmdW && (hostData[7:0] == 8'h12 || hostData[7:0] == 8'h13)) begin
         modeWanted      <= 1'b1;
         modeWantPartial <= (hostData[7:0] == 8'h12);
      end else if (frameStart) begin
         modeWanted <= 1'b0;
      end
   end
   sequence quietFrame;
      frameStart && !cmdW && modeWanted;
   endsequence
   sequence stopThenData;
      cmdW && hostData[7:0] != 8'h2C ##1 hostWrite && cmdDataSelect;
   endsequence
   partial_enter_a: assert property (quietFrame ##0 modeWantPartial |=> panelState.partialMode)
      else $error("partial mode not entered");
   normal_return_a: assert property (quietFrame ##0 !modeWantPartial |=> !panelState.partialMode)
      else $error("normal mode not entered");
   mode_defer_a: assert property ($changed(panelState.partialMode) |-> $past(frameStart))
      else $error("mode changed outside frame start");
   invert_off_a: assert property (cmdIs(8'h20) |=> !panelState.invertOn && $stable(panelState.displayOn))
      else $error("inversion not stopped");
   invert_on_a: assert property (cmdIs(8'h21) |=> panelState.invertOn
      && (!panelState.backlightOn || $past(panelState.invertOn)))
      else $error("inversion or backlight wrong");
   display_off_a: assert property (cmdIs(8'h28) |=> !panelState.displayOn && $stable(panelState.invertOn))
      else $error("display not stopped");
   display_on_a: assert property (cmdIs(8'h29) |=> panelState.displayOn)
      else $error("display not started");
   store_cause_a: assert property (memWrite.enable |-> $past(hostWrite && cmdDataSelect))
      else $error("store without data word");
   write_stop_a: assert property (stopThenData |=> !memWrite.enable)
      else $error("store after other command");
endmodule : dmw_command_decoder_chk

//--- dmw_command_decoder_tb.sv
`timescale 1ns/100ps
module dmw_command_decoder_tb;
   typedef struct packed {
      logic [7:0] code;
      logic [3:0] st;
   } dmw_row_type;
   logic mclk, rst_n, frameStart, psel, penable, pwrite, pready, pslverr;
   logic hostWrite, cmdDataSelect;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [23:0] hostData;
   dmw_pkg::dmw_memwr_type memWrite;
   dmw_pkg::dmw_panel_type panelState;
   dmw_pkg::dmw_memwr_type got[$], exp[$];
   int fail_count, samples_checked;
   dmw_row_type rows [8] = '{'{8'h29, 4'h3}, '{8'h29, 4'h3}, '{8'h21, 4'h6}, '{8'h21, 4'h6},
                             '{8'h20, 4'h2}, '{8'h20, 4'h2}, '{8'h28, 4'h0}, '{8'h28, 4'h0}};
   dmw_command_decoder dut_u (.mclk(mclk), .rst_n(rst_n), .hostWrite(hostWrite),
      .cmdDataSelect(cmdDataSelect), .hostData(hostData), .frameStart(frameStart), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .memWrite(memWrite), .panelState(panelState));
   dmw_host_model host_u (.mclk(mclk), .hostWrite(hostWrite), .cmdDataSelect(cmdDataSelect),
      .hostData(hostData));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) if (memWrite.enable === 1'b1) got.push_back(memWrite);
   task automatic wrap_up();
      if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string n, input logic [44:0] e, input logic [44:0] s);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                      input logic err);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         fail_count++;
         wrap_up();
      end
      if (!w) chk("prdata", e, prdata);
      chk("pslverr", err, pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic drain();
      int i;
      for (i = 0; i < 200 && host_u.q.size() != 0; i++) @(posedge mclk);
      if (i >= 200) begin
         fail_count++;
         wrap_up();
      end
      repeat (3) @(posedge mclk);
   endtask : drain
   task automatic frame();
      frameStart <= 1'b1;
      @(posedge mclk);
      frameStart <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : frame
   task automatic cmd(input logic [7:0] c);
      host_u.put(1'b0, {16'h0000, c});
      drain();
   endtask : cmd
   task automatic rng(input logic [7:0] c, input logic [9:0] f, input logic [9:0] l);
      host_u.put(1'b0, {16'h0000, c});
      host_u.put(1'b1, {22'h0, f[9:8]});
      host_u.put(1'b1, {16'h0000, f[7:0]});
      host_u.put(1'b1, {22'h0, l[9:8]});
      host_u.put(1'b1, {16'h0000, l[7:0]});
      drain();
   endtask : rng
   task automatic px(input logic [9:0] c, input logic [9:0] p, input logic [23:0] d);
      exp.push_back({1'b1, c, p, d});
   endtask : px
   task automatic mem(input logic [6:0] ctrl, input int n);
      apb(1'b1, 12'h000, {25'h0, ctrl}, 32'h0000_0000, 1'b0);
      host_u.put(1'b0, 24'h00_002C);
      for (int i = 1; i <= n; i++) begin
         host_u.put(1'b1, 24'(i));
         if (i == 2) host_u.gap();
      end
      host_u.put(1'b0, 24'h00_0000);
      host_u.put(1'b1, 24'h00_0077);
      drain();
      chk("stores", 45'(exp.size()), 45'(got.size()));
      foreach (exp[i]) if (i < got.size()) chk("store", exp[i], got[i]);
      got.delete();
      exp.delete();
   endtask : mem
   initial begin
      {rst_n, frameStart, psel, penable, pwrite} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      chk("panel", 0, panelState);
      apb(1'b0, 12'h004, 0, 0, 1'b0);
      apb(1'b0, 12'h0FC, 0, 0, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0010, 0, 1'b0);
      apb(1'b0, 12'h000, 0, 32'h0000_0010, 1'b0);
      foreach (rows[i]) begin
         cmd(rows[i].code);
         chk("panel", rows[i].st, panelState);
      end
      cmd(8'h12);
      chk("partial", 0, panelState.partialMode);
      frame();
      chk("partial", 1, panelState.partialMode);
      cmd(8'h12);
      frame();
      chk("partial", 1, panelState.partialMode);
      cmd(8'h13);
      chk("partial", 1, panelState.partialMode);
      frame();
      chk("partial", 0, panelState.partialMode);
      rng(8'h2A, 10'h002, 10'h003);
      rng(8'h2B, 10'h005, 10'h006);
      px(2, 5, 1);
      px(3, 5, 2);
      px(2, 6, 3);
      px(3, 6, 4);
      mem(7'h00, 5);
      px(2, 5, 1);
      px(3, 5, 2);
      px(2, 6, 3);
      px(3, 6, 4);
      px(2, 5, 5);
      mem(7'h01, 5);
      rng(8'h2A, 10'h000, 10'h1E0);
      apb(1'b0, 12'h008, 0, 32'h0003_0002, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0002, 0, 1'b0);
      rng(8'h2B, 10'h000, 10'h140);
      px(2, 5, 1);
      px(2, 6, 2);
      mem(7'h02, 2);
      px(2, 6, 1);
      px(3, 6, 2);
      mem(7'h08, 2);
      px(2, 5, 24'h00_0102);
      mem(7'h20, 3);
      px(3, 5, 24'h01_0203);
      mem(7'h44, 3);
      cmd(8'h29);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      chk("panel", 0, panelState);
      apb(1'b0, 12'h000, 0, 0, 1'b0);
      apb(1'b0, 12'h008, 0, 32'h01DF_0000, 1'b0);
      wrap_up();
   end
endmodule : dmw_command_decoder_tb
bind dmw_command_decoder dmw_command_decoder_chk chk_u (.mclk(mclk), .rst_n(rst_n), .hostWrite(hostWrite),
   .cmdDataSelect(cmdDataSelect), .hostData(hostData), .frameStart(frameStart), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .memWrite(memWrite), .panelState(panelState));

//--- dmw_host_model.sv
`timescale 1ns/100ps
module dmw_host_model (
   // Clock.
   input  wire  logic        mclk,
   // Host command bus.
   output       logic        hostWrite,
   output       logic        cmdDataSelect,
   output       logic [23:0] hostData
);
   logic [25:0] q[$];
   logic [25:0] w;
   initial begin
      hostWrite = 1'b0;
      cmdDataSelect = 1'b0;
      hostData = 24'h00_0000;
   end
   // Commands travel as plain command words on the parallel bus.
   // One queued word per edge; idle cycles drive changing junk data.
   always @(posedge mclk) begin
      w = (q.size() != 0) ? q.pop_front() : 26'h000_0000;
      hostWrite <= w[25];
      cmdDataSelect <= w[24];
      hostData <= w[25] ? w[23:0] : ~hostData;
   end
   task automatic put(input logic c, input logic [23:0] d);
      q.push_back({1'b1, c, d});
   endtask : put
   task automatic gap();
      q.push_back(26'h000_0000);
   endtask : gap
endmodule : dmw_host_model

//--- dmw_pkg.sv
package dmw_pkg;

   // ************************************************************
   // Command codes and parameter limits.
   // ************************************************************
   localparam logic [7:0] CMD_PARTIAL_ON  = 8'h12;
   localparam logic [7:0] CMD_NORMAL_ON   = 8'h13;
   localparam logic [7:0] CMD_INVERT_OFF  = 8'h20;
   localparam logic [7:0] CMD_INVERT_ON   = 8'h21;
   localparam logic [7:0] CMD_DISPLAY_OFF = 8'h28;
   localparam logic [7:0] CMD_DISPLAY_ON  = 8'h29;
   localparam logic [7:0] CMD_COLUMN_SET  = 8'h2A;
   localparam logic [7:0] CMD_PAGE_SET    = 8'h2B;
   localparam logic [7:0] CMD_MEM_WRITE   = 8'h2C;

   localparam logic [9:0] COL_LIMIT_NARROW  = 10'h1DF;
   localparam logic [9:0] COL_LIMIT_WIDE    = 10'h35F;
   localparam logic [9:0] PAGE_LIMIT_NARROW = 10'h1DF;
   localparam logic [9:0] PAGE_LIMIT_WIDE   = 10'h13F;

   // ************************************************************
   // Register map, field positions and reset values.
   // ************************************************************
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_STATUS  = 12'h004;
   localparam logic [11:0] ADDR_COLWIN  = 12'h008;
   localparam logic [11:0] ADDR_PAGEWIN = 12'h00C;
   localparam logic [11:0] ADDR_CURSOR  = 12'h010;

   localparam int unsigned CTRL_WRAP_BIT  = 0;
   localparam int unsigned CTRL_SWAP_BIT  = 1;
   localparam int unsigned CTRL_CMIR_BIT  = 2;
   localparam int unsigned CTRL_PMIR_BIT  = 3;
   localparam int unsigned CTRL_BLC_BIT   = 4;
   localparam int unsigned CTRL_WPP_LSB   = 5;
   localparam int unsigned CTRL_WIDTH     = 7;

   localparam logic [6:0] CTRL_RESET      = 7'h00;
   localparam logic [9:0] FIRST_RESET     = 10'h000;
   localparam logic [9:0] LAST_COL_RESET  = 10'h1DF;
   localparam logic [9:0] LAST_PAGE_RESET = 10'h1DF;

   // ************************************************************
   // Types.
   // ************************************************************
   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_COLPAR  = 4'b0010,
      ST_PAGEPAR = 4'b0100,
      ST_MEMWR   = 4'b1000
   } dmw_state_type;

   typedef struct packed {
      logic        enable;
      logic [9:0]  column;
      logic [9:0]  page;
      logic [23:0] pixel;
   } dmw_memwr_type;

   typedef struct packed {
      logic partialMode;
      logic invertOn;
      logic displayOn;
      logic backlightOn;
   } dmw_panel_type;

endpackage : dmw_pkg
